// [hws_pkg.sv]
// shared constants and types of the hall wheel config bank
package hws_pkg;
  // register byte addresses
  localparam logic [7:0] A_RATIO  = 8'h78;
  localparam logic [7:0] A_SIN    = 8'h79;
  localparam logic [7:0] A_COS    = 8'h7A;
  localparam logic [7:0] A_BETA   = 8'h7B;
  localparam logic [7:0] A_WAKE   = 8'h7C;
  localparam logic [7:0] A_INTV   = 8'h7D;
  localparam logic [7:0] A_OFS_LO = 8'h7E;
  localparam logic [7:0] A_OFS_HI = 8'h7F;
  localparam logic [7:0] A_SYS    = 8'hD0;
  localparam logic [7:0] A_CHAN   = 8'hD1;
  // ratio register fields
  localparam int RAT_QUAD = 5;
  localparam int RAT_INV  = 3;
  // system control fields
  localparam int SYS_SRST = 7;
  localparam int SYS_ACK  = 6;
  localparam int SYS_EVT  = 5;
  localparam int SYS_OSC  = 4;
  localparam int SYS_COMM = 3;
  localparam int SYS_BAND = 2;
  localparam int SYS_TUNE = 1;
  localparam int SYS_SEED = 0;
  // wake preload fields
  localparam int WK_THR = 5;
  // reset values and other fixed constants
  localparam logic [7:0] SIN_RST  = 8'h00;
  localparam logic [7:0] COS_RST  = 8'h00;
  localparam logic [7:0] BETA_RST = 8'h08;
  localparam logic [7:0] WAKE_RST = 8'hFF;
  localparam logic [7:0] INTV_RST = 8'h03;
  localparam logic [5:0] CHAN_RST = 6'h3F;
  localparam logic [5:0] ROT_CHAN = 6'h3C;
  localparam logic [4:0] TMR_AWAKE = 5'h1F;
  localparam logic [8:0] OCT_DEG  = 9'h02D;
  localparam logic [7:0] UNMAPPED = 8'h00;
  // soft reset sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_SRST = 2'b10
  } hws_state_t;
  // quadrature code: octant index of an angle, modulo 4
  function automatic logic [1:0] quad_code(input logic [8:0] ang);
    logic [8:0] lim;
    logic [2:0] oct;
    lim = OCT_DEG;
    oct = 3'h0;
    for (int k = 1; k < 8; k++) begin
      if (ang >= lim) begin
        oct = 3'(k);
      end
      lim = 9'(lim + OCT_DEG);
    end
    return oct[1:0];
  endfunction
endpackage

// [hws_octant.sv]
// octant tracker producing the two-bit quadrature code
module hws_octant (
  input  wire logic       i_ref_clk,   // system clock
  input  wire logic       i_rst_n,     // async reset, low
  input  wire logic       i_angle_vld, // new angle strobe
  input  wire logic [8:0] i_angle,     // angle 0..359
  output logic      [1:0] o_quad       // quadrature code
);
  typedef struct packed {
    logic [1:0] quad; // current code
  } hws_oct_t;
  hws_oct_t s_q;
  hws_oct_t s_d;

  // next code on each new angle
  always_comb begin
    s_d = s_q;
    if (i_angle_vld) begin
      s_d.quad = hws_pkg::quad_code(i_angle);
    end
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_quad = s_q.quad;

  a_quad_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_angle_vld |=> o_quad == hws_pkg::quad_code($past(i_angle)))
    else $error("quadrature code does not follow angle");
endmodule

// [hws_wheel_wake.sv]
// wheel wake movement timer and movement counter
module hws_wheel_wake (
  input  wire logic       i_ref_clk, // system clock
  input  wire logic       i_rst_n,   // async reset, low
  input  wire logic [2:0] i_thresh,  // counter threshold
  input  wire logic [4:0] i_preload, // timer preload
  input  wire logic       i_awake,   // wheel awake level
  input  wire logic       i_move,    // movement event
  input  wire logic       i_tick,    // timer tick enable
  output logic            o_wake,    // wake pulse
  output logic      [4:0] o_timer    // movement timer
);
  typedef struct packed {
    logic [4:0] tmr;  // countdown
    logic [3:0] cnt;  // movement count
    logic       wake; // wake pulse
  } hws_wk_t;
  hws_wk_t s_q;
  hws_wk_t s_d;

  // timer and counter update
  always_comb begin
    s_d = s_q;
    s_d.wake = 1'b0;
    if (i_awake) begin
      s_d.tmr = (i_preload == 5'h00) ? hws_pkg::TMR_AWAKE : i_preload;
      s_d.cnt = 4'h0;
    end else if (i_preload != 5'h00) begin
      if (i_tick && s_q.tmr <= 5'h01) begin
        s_d.tmr = i_preload;
        s_d.cnt = 4'h0;
      end else if (i_tick) begin
        s_d.tmr = 5'(s_q.tmr - 5'h01);
      end
    end
    if (!i_awake && i_move && s_q.tmr != 5'h00) begin
      s_d.cnt = (s_q.cnt == 4'hF) ? s_q.cnt : 4'(s_q.cnt + 4'h1);
      if (4'(s_q.cnt + 4'h1) >= {1'b0, i_thresh}) begin
        s_d.wake = 1'b1;
        s_d.cnt  = 4'h0;
      end
    end
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_wake  = s_q.wake;
  assign o_timer = s_q.tmr;

  a_awake_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_awake && i_preload == 5'h00 |=> o_timer == hws_pkg::TMR_AWAKE)
    else $error("awake timer not loaded with 31");
  a_sleep_stop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_awake && $past(!i_awake) && i_preload == 5'h00 && $past(i_preload) == 5'h00
    |-> $stable(o_timer))
    else $error("sleeping timer moved with zero preload");
  a_no_wake_out: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_wake |-> $past(i_move) && $past(o_timer) != 5'h00 && !$past(i_awake))
    else $error("wake without movement inside window");
endmodule

// [hws_config_regs.sv]
// configuration and status register bank of the hall wheel sensor
module hws_config_regs (
  input  wire logic        i_ref_clk,     // 25 MHz clock
  input  wire logic        i_rst_n,       // async reset, low
  input  wire logic        i_wr_en,       // register write strobe
  input  wire logic        i_rd_en,       // register read strobe
  input  wire logic  [7:0] i_addr,        // register address
  input  wire logic  [7:0] i_wdata,       // write data
  input  wire logic        i_angle_vld,   // new angle strobe
  input  wire logic  [8:0] i_angle,       // wheel angle 0..359
  input  wire logic        i_ratio_neg,   // ratio sign
  input  wire logic        i_den_neg,     // denominator sign
  input  wire logic        i_num_neg,     // numerator sign
  input  wire logic [15:0] i_wheel_ofs,   // wheel offset degrees
  input  wire logic        i_wheel_awake, // wheel awake level
  input  wire logic        i_move,        // movement event
  input  wire logic        i_tick,        // movement timer tick
  input  wire logic        i_tune_busy,   // tuning running
  input  wire logic        i_tune_done,   // tuning finished pulse
  input  wire logic        i_seed_done,   // reseed finished pulse
  output logic       [7:0] o_rdata,       // read data
  output logic             o_rd_valid,    // read data valid pulse
  output logic       [1:0] o_quad,        // quadrature code
  output logic             o_dir_invert,  // invert degree direction
  output logic       [7:0] o_sin_const,   // sine constant
  output logic       [7:0] o_cos_const,   // cosine constant
  output logic       [7:0] o_filter_beta, // filter start value
  output logic       [7:0] o_interval,    // interval size degrees
  output logic             o_wheel_wake,  // wheel wake pulse
  output logic       [4:0] o_move_timer,  // movement timer
  output logic             o_soft_reset,  // soft reset pulse
  output logic             o_reset_event, // reset occurred event
  output logic             o_event_mode,  // event comms mode
  output logic             o_osc_8mhz,    // main clock at 8 MHz
  output logic             o_comms_en,    // host comms allowed
  output logic             o_band_small,  // one sixteenth band
  output logic             o_tune_start,  // start tuning pulse
  output logic             o_seed_start,  // start reseed pulse
  output logic       [5:0] o_chan_en,     // channel enables
  output logic             o_rot_en       // rotation function on
);
  // state of the bank, apart from the octant tracker and wake timer submodules
  typedef struct packed {
    hws_pkg::hws_state_t st;  // sequencer state
    logic [7:0]  sin_c;       // sine constant
    logic [7:0]  cos_c;       // cosine constant
    logic [7:0]  beta;        // filter start value
    logic [7:0]  wake;        // wake preload
    logic [7:0]  intv;        // interval size
    logic        inv;         // direction invert
    logic [2:0]  sign;        // sign flags
    logic [15:0] ofs;         // wheel offset copy
    logic        evt;         // event mode
    logic        osc8;        // 8 MHz select
    logic        comm;        // comms during tuning
    logic        band;        // small band
    logic        ack_pend;    // acknowledge pending
    logic        tune_pend;   // tuning pending
    logic        seed_pend;   // reseed pending
    logic        rst_flag;    // reset occurred
    logic [5:0]  chan;        // channel mask
    logic        tune_go;     // tuning start pulse
    logic        seed_go;     // reseed start pulse
    logic        srst_go;     // soft reset pulse
    logic        comms;       // comms allowed
    logic        rot;         // rotation enabled
    logic [7:0]  rdata;       // read data
    logic        rvld;        // read valid
  } hws_regs_t;

  hws_regs_t s_q;  // registered state
  hws_regs_t s_d;  // next state
  logic [1:0] quad; // octant tracker output
  logic       wr_sys; // write to control register

  // octant tracker
  hws_octant u_octant (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_angle_vld (i_angle_vld),
    .i_angle     (i_angle),
    .o_quad      (quad)
  );

  // wheel wake timer and counter
  hws_wheel_wake u_wake (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_thresh  (s_q.wake[7:hws_pkg::WK_THR]),
    .i_preload (s_q.wake[hws_pkg::WK_THR-1:0]),
    .i_awake   (i_wheel_awake),
    .i_move    (i_move),
    .i_tick    (i_tick),
    .o_wake    (o_wheel_wake),
    .o_timer   (o_move_timer)
  );

  assign wr_sys = i_wr_en && i_addr == hws_pkg::A_SYS;

  // read view of the control register
  function automatic logic [7:0] sys_view(input hws_regs_t s);
    logic [7:0] v;
    v = 8'h00;
    v[hws_pkg::SYS_SRST] = (s.st == hws_pkg::ST_SRST);
    v[hws_pkg::SYS_ACK]  = s.ack_pend;
    v[hws_pkg::SYS_EVT]  = s.evt;
    v[hws_pkg::SYS_OSC]  = s.osc8;
    v[hws_pkg::SYS_COMM] = s.comm;
    v[hws_pkg::SYS_BAND] = s.band;
    v[hws_pkg::SYS_TUNE] = s.tune_pend;
    v[hws_pkg::SYS_SEED] = s.seed_pend;
    return v;
  endfunction

  // next state of the bank
  always_comb begin
    s_d = s_q;
    s_d.rvld    = 1'b0;
    s_d.tune_go = 1'b0;
    s_d.seed_go = 1'b0;
    s_d.srst_go = 1'b0;
    s_d.sign = {i_ratio_neg, i_den_neg, i_num_neg};
    s_d.ofs = i_wheel_ofs;
    s_d.comms = s_q.comm || !i_tune_busy;
    s_d.rot = (s_q.chan & hws_pkg::ROT_CHAN) == hws_pkg::ROT_CHAN;
    if (i_tune_done) begin
      s_d.tune_pend = 1'b0;
    end
    if (i_seed_done) begin
      s_d.seed_pend = 1'b0;
    end
    if (s_q.ack_pend) begin
      s_d.ack_pend = 1'b0;
      s_d.rst_flag = 1'b0;
    end
    // register writes
    if (i_wr_en && s_q.st == hws_pkg::ST_RUN) begin
      case (i_addr)
        // direction invert is the only writable bit
        hws_pkg::A_RATIO: begin
          s_d.inv = i_wdata[hws_pkg::RAT_INV];
        end
        hws_pkg::A_SIN: begin
          s_d.sin_c = i_wdata;
        end
        hws_pkg::A_COS: begin
          s_d.cos_c = i_wdata;
        end
        hws_pkg::A_BETA: begin
          s_d.beta = i_wdata;
        end
        hws_pkg::A_WAKE: begin
          s_d.wake = i_wdata;
        end
        // host keeps this within 10 to 180
        hws_pkg::A_INTV: begin
          s_d.intv = i_wdata;
        end
        hws_pkg::A_SYS: begin
          s_d.evt  = i_wdata[hws_pkg::SYS_EVT];
          s_d.osc8 = i_wdata[hws_pkg::SYS_OSC];
          s_d.comm = i_wdata[hws_pkg::SYS_COMM];
          s_d.band = i_wdata[hws_pkg::SYS_BAND];
          // set-only commands, a new request wins over done
          if (i_wdata[hws_pkg::SYS_TUNE]) begin
            s_d.tune_pend = 1'b1;
            s_d.tune_go   = 1'b1;
          end
          if (i_wdata[hws_pkg::SYS_SEED]) begin
            s_d.seed_pend = 1'b1;
            s_d.seed_go   = 1'b1;
          end
          if (i_wdata[hws_pkg::SYS_ACK]) begin
            s_d.ack_pend = 1'b1;
          end
          if (i_wdata[hws_pkg::SYS_SRST]) begin
            s_d.st = hws_pkg::ST_SRST;
          end
        end
        hws_pkg::A_CHAN: begin
          s_d.chan = i_wdata[5:0];
        end
        default: begin
          // writes elsewhere are ignored
        end
      endcase
    end
    // soft reset sequencer
    case (s_q.st)
      hws_pkg::ST_RUN: begin
        // normal operation
      end
      hws_pkg::ST_SRST: begin
        // restore defaults and report the reset
        s_d          = '0;
        s_d.st       = hws_pkg::ST_RUN;
        s_d.sin_c    = hws_pkg::SIN_RST;
        s_d.cos_c    = hws_pkg::COS_RST;
        s_d.beta     = hws_pkg::BETA_RST;
        s_d.wake     = hws_pkg::WAKE_RST;
        s_d.intv     = hws_pkg::INTV_RST;
        s_d.chan     = hws_pkg::CHAN_RST;
        s_d.rst_flag = 1'b1;
        s_d.srst_go  = 1'b1;
        s_d.comms    = 1'b1;
      end
      default: begin
        s_d.st = hws_pkg::ST_RUN;
      end
    endcase
    // read path, one cycle latency
    if (i_rd_en) begin
      s_d.rvld = 1'b1;
      case (i_addr)
        hws_pkg::A_RATIO: s_d.rdata = {1'b0, quad, 1'b0, s_q.inv, s_q.sign};
        hws_pkg::A_SIN:   s_d.rdata = s_q.sin_c;
        hws_pkg::A_COS:   s_d.rdata = s_q.cos_c;
        hws_pkg::A_BETA:  s_d.rdata = s_q.beta;
        hws_pkg::A_WAKE:  s_d.rdata = s_q.wake;
        hws_pkg::A_INTV:  s_d.rdata = s_q.intv;
        hws_pkg::A_OFS_LO: s_d.rdata = s_q.ofs[7:0];
        hws_pkg::A_OFS_HI: s_d.rdata = s_q.ofs[15:8];
        hws_pkg::A_SYS:   s_d.rdata = sys_view(s_q);
        hws_pkg::A_CHAN:  s_d.rdata = {2'b00, s_q.chan};
        default:          s_d.rdata = hws_pkg::UNMAPPED;
      endcase
    end
  end

  // state register, power-on defaults
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q          <= '0;
      s_q.st       <= hws_pkg::ST_RUN;
      s_q.sin_c    <= hws_pkg::SIN_RST;
      s_q.cos_c    <= hws_pkg::COS_RST;
      s_q.beta     <= hws_pkg::BETA_RST;
      s_q.wake     <= hws_pkg::WAKE_RST;
      s_q.intv     <= hws_pkg::INTV_RST;
      s_q.chan     <= hws_pkg::CHAN_RST;
      s_q.rst_flag <= 1'b1;
      s_q.comms    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs, all from state flops
  assign o_rdata       = s_q.rdata;
  assign o_rd_valid    = s_q.rvld;
  assign o_quad        = quad;
  assign o_dir_invert  = s_q.inv;
  assign o_sin_const   = s_q.sin_c;
  assign o_cos_const   = s_q.cos_c;
  assign o_filter_beta = s_q.beta;
  assign o_interval    = s_q.intv;
  assign o_soft_reset  = s_q.srst_go;
  assign o_reset_event = s_q.rst_flag;
  assign o_event_mode  = s_q.evt;
  assign o_osc_8mhz    = s_q.osc8;
  assign o_comms_en    = s_q.comms;
  assign o_band_small  = s_q.band;
  assign o_tune_start  = s_q.tune_go;
  assign o_seed_start  = s_q.seed_go;
  assign o_chan_en     = s_q.chan;
  assign o_rot_en      = s_q.rot;

  // checks
  a_invert_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_wr_en && i_addr == hws_pkg::A_RATIO && s_q.st == hws_pkg::ST_RUN
    |=> o_dir_invert == $past(i_wdata[hws_pkg::RAT_INV]))
    else $error("direction invert not written");
  a_sign_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_rd_en && i_addr == hws_pkg::A_RATIO ##1 1'b1
    |-> o_rd_valid && o_rdata[2:0] == $past(s_q.sign) && o_rdata[6:5] == $past(quad))
    else $error("ratio readback wrong");
  a_const_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_wr_en && i_addr == hws_pkg::A_SIN && s_q.st == hws_pkg::ST_RUN
    |=> o_sin_const == $past(i_wdata))
    else $error("sine constant not written");
  a_sin_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !(i_wr_en && i_addr == hws_pkg::A_SIN) && s_q.st == hws_pkg::ST_RUN |=> $stable(o_sin_const))
    else $error("sine constant changed without a write");
  a_cos_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_wr_en && i_addr == hws_pkg::A_COS && s_q.st == hws_pkg::ST_RUN
    |=> o_cos_const == $past(i_wdata))
    else $error("cosine constant not written");
  a_srst_defaults: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_soft_reset |-> o_filter_beta == hws_pkg::BETA_RST && o_chan_en == hws_pkg::CHAN_RST
    && o_interval == hws_pkg::INTV_RST
    && o_reset_event)
    else $error("soft reset defaults wrong");
  a_srst_seq: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_sys && i_wdata[hws_pkg::SYS_SRST] && s_q.st == hws_pkg::ST_RUN |=> ##1 o_soft_reset ##1 !o_soft_reset)
    else $error("soft reset sequence wrong");
  a_ack_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_reset_event && !s_q.ack_pend && !(wr_sys && i_wdata[hws_pkg::SYS_ACK]) |=> o_reset_event)
    else $error("reset event dropped without acknowledge");
  a_ack_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_sys && i_wdata[hws_pkg::SYS_ACK] && !i_wdata[hws_pkg::SYS_SRST] && s_q.st == hws_pkg::ST_RUN
    |=> ##1 !o_reset_event)
    else $error("acknowledge did not clear event");
  a_comms_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_q.st == hws_pkg::ST_RUN && !s_q.comm && i_tune_busy |=> !o_comms_en)
    else $error("comms not blocked during tuning");
  a_tune_pend: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_tune_start |-> s_q.tune_pend
    && $past(wr_sys && i_wdata[hws_pkg::SYS_TUNE] && s_q.st == hws_pkg::ST_RUN))
    else $error("tuning start without pending flag");
  a_rot_enable: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_q.st == hws_pkg::ST_RUN |=> o_rot_en == (($past(o_chan_en) & hws_pkg::ROT_CHAN) == hws_pkg::ROT_CHAN))
    else $error("rotation enable wrong");
  c_soft_reset: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_soft_reset);
  c_tune_done:  cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_tune_start ##[1:20] !s_q.tune_pend);
  c_wake:       cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_wheel_wake);
endmodule

// [hws_host_model.sv]
// host side model driving the register strobe port
module hws_host_model (
  input  wire logic       i_ref_clk,  // system clock
  input  wire logic [7:0] i_rdata,    // read data
  input  wire logic       i_rd_valid, // read data valid
  output logic            o_wr_en,    // write strobe
  output logic            o_rd_en,    // read strobe
  output logic      [7:0] o_addr,     // register address
  output logic      [7:0] o_wdata     // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  realtime t_rd_end = -1.0; // when the last read released the port
  realtime t_wr_end = -1.0; // when the last write released the port
  // idle port at time zero
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end
  // write: called at a falling edge, held through the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    // a port released in this very step gets one idle clock first
    if (t_rd_end == $realtime || t_wr_end == $realtime) begin
      @(negedge i_ref_clk);
    end
    o_addr  = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    o_wr_en = 1'b0;
    o_wdata = ~d; // released data no longer shows the last value
    t_wr_end = $realtime;
  endtask
  // read: answer sampled at the falling edge half a cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    // only a read that just released address and strobe must wait
    if (t_rd_end == $realtime) begin
      @(negedge i_ref_clk);
    end
    o_addr  = a;
    o_rd_en = 1'b1;
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    o_rd_en = 1'b0;
    o_addr  = ~a;
    d = i_rdata;
    v = i_rd_valid;
    t_rd_end = $realtime;
  endtask
endmodule

// [test_hws_config_regs.sv]
// self-checking bench of the hall wheel config bank
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module test_hws_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_ref_clk = 1'b0; // 25 MHz clock
  logic        i_rst_n, i_wr_en, i_rd_en, i_angle_vld, i_ratio_neg, i_den_neg, i_num_neg;
  logic        i_wheel_awake, i_move, i_tick, i_tune_busy, i_tune_done, i_seed_done, o_rd_valid;
  logic        o_dir_invert, o_wheel_wake, o_soft_reset, o_reset_event, o_event_mode, o_osc_8mhz;
  logic        o_comms_en, o_band_small, o_tune_start, o_seed_start, o_rot_en;
  logic  [7:0] i_addr, i_wdata, o_rdata, o_sin_const, o_cos_const, o_filter_beta, o_interval;
  logic  [8:0] i_angle;      // wheel angle
  logic [15:0] i_wheel_ofs;  // wheel offset
  logic  [1:0] o_quad;       // quadrature code
  logic  [4:0] o_move_timer; // movement timer
  logic  [5:0] o_chan_en;    // channel enables
  int          bad_count, samples_checked;
  hws_config_regs dut (.i_ref_clk, .i_rst_n, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .i_angle_vld,
    .i_angle, .i_ratio_neg, .i_den_neg, .i_num_neg, .i_wheel_ofs, .i_wheel_awake, .i_move, .i_tick,
    .i_tune_busy, .i_tune_done, .i_seed_done, .o_rdata, .o_rd_valid, .o_quad, .o_dir_invert,
    .o_sin_const, .o_cos_const, .o_filter_beta, .o_interval, .o_wheel_wake, .o_move_timer,
    .o_soft_reset, .o_reset_event, .o_event_mode, .o_osc_8mhz, .o_comms_en, .o_band_small,
    .o_tune_start, .o_seed_start, .o_chan_en, .o_rot_en);
  hws_host_model host (.i_ref_clk, .i_rdata(o_rdata), .i_rd_valid(o_rd_valid), .o_wr_en(i_wr_en),
    .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wdata(i_wdata));
  // free running 25 MHz clock
  always #20 i_ref_clk = ~i_ref_clk;
  // read one register and compare data and valid pulse
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    `CHK("rd_valid", 1'b1, v)
    `CHK("rdata", e, d)
  endtask
  // one strobe pulse on an angle, done, tick or movement input
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge i_ref_clk);
    s = 1'b0;
  endtask
  // defaults, unmapped read, acknowledge and soft reset
  task automatic t_reset();
    rd_chk(hws_pkg::A_BETA, 8'h08);
    rd_chk(hws_pkg::A_CHAN, 8'h3F);
    rd_chk(hws_pkg::A_WAKE, 8'hFF);
    rd_chk(8'h90, 8'h00);
    `CHK("reset_event", 1'b1, o_reset_event)
    host.wr(hws_pkg::A_SYS, 8'h40);
    rd_chk(hws_pkg::A_SYS, 8'h40);
    `CHK("reset_event", 1'b0, o_reset_event)
    host.wr(hws_pkg::A_BETA, 8'h55);
    `CHK("beta", 8'h55, o_filter_beta)
    @(negedge i_ref_clk);
    host.wr(hws_pkg::A_SYS, 8'h80);
    rd_chk(hws_pkg::A_SYS, 8'h80);
    `CHK("soft_reset", 1'b1, o_soft_reset)
    `CHK("reset_event", 1'b1, o_reset_event)
    rd_chk(hws_pkg::A_BETA, 8'h08);
    `CHK("beta", 8'h08, o_filter_beta)
    rd_chk(hws_pkg::A_SYS, 8'h00);
    $display("test reset done");
  endtask
  // ratio flags, quadrature, constants, offset, interval
  task automatic t_angle();
    i_ratio_neg = 1'b1;
    i_num_neg = 1'b1;
    i_angle = 9'd100;
    pulse(i_angle_vld);
    `CHK("quad", 2'h2, o_quad)
    host.wr(hws_pkg::A_RATIO, 8'hFF);
    `CHK("dir_invert", 1'b1, o_dir_invert)
    rd_chk(hws_pkg::A_RATIO, 8'h4D);
    i_angle = 9'd359;
    pulse(i_angle_vld);
    `CHK("quad", 2'h3, o_quad)
    host.wr(hws_pkg::A_SIN, 8'hB4);
    rd_chk(hws_pkg::A_SIN, 8'hB4);
    `CHK("sin", 8'hB4, o_sin_const)
    host.wr(hws_pkg::A_COS, 8'h68);
    `CHK("cos", 8'h68, o_cos_const)
    i_wheel_ofs = 16'h0167;
    host.wr(hws_pkg::A_OFS_LO, 8'hAA);
    rd_chk(hws_pkg::A_OFS_LO, 8'h67);
    rd_chk(hws_pkg::A_OFS_HI, 8'h01);
    host.wr(hws_pkg::A_INTV, 8'h5A);
    `CHK("interval", 8'h5A, o_interval)
    $display("test angle done");
  endtask
  // command bits, modes and communication gating
  task automatic t_ctrl();
    i_tune_busy = 1'b1;
    host.wr(hws_pkg::A_SYS, 8'h3F);
    `CHK("tune_start", 1'b1, o_tune_start)
    `CHK("seed_start", 1'b1, o_seed_start)
    rd_chk(hws_pkg::A_SYS, 8'h3F);
    `CHK("modes", 4'hF, {o_event_mode, o_osc_8mhz, o_band_small, o_comms_en})
    pulse(i_tune_done);
    rd_chk(hws_pkg::A_SYS, 8'h3D);
    pulse(i_seed_done);
    rd_chk(hws_pkg::A_SYS, 8'h3C);
    host.wr(hws_pkg::A_SYS, 8'h00);
    rd_chk(hws_pkg::A_SYS, 8'h00);
    `CHK("modes", 4'h0, {o_event_mode, o_osc_8mhz, o_band_small, o_comms_en})
    `CHK("comms_en", 1'b0, o_comms_en)
    i_tune_busy = 1'b0;
    $display("test ctrl done");
  endtask
  // channel mask, rotation enable and wheel wake
  task automatic t_wheel();
    host.wr(hws_pkg::A_CHAN, 8'h3B);
    rd_chk(hws_pkg::A_CHAN, 8'h3B);
    `CHK("chan_en", 6'h3B, o_chan_en)
    `CHK("rot_en", 1'b0, o_rot_en)
    host.wr(hws_pkg::A_CHAN, 8'h3C);
    rd_chk(hws_pkg::A_CHAN, 8'h3C);
    `CHK("rot_en", 1'b1, o_rot_en)
    i_wheel_awake = 1'b1;
    host.wr(hws_pkg::A_WAKE, 8'h25);
    @(negedge i_ref_clk);
    `CHK("timer", 5'h05, o_move_timer)
    host.wr(hws_pkg::A_WAKE, 8'h20);
    @(negedge i_ref_clk);
    `CHK("timer", 5'h1F, o_move_timer)
    i_wheel_awake = 1'b0;
    pulse(i_tick);
    `CHK("timer", 5'h1F, o_move_timer)
    i_wheel_awake = 1'b1;
    host.wr(hws_pkg::A_WAKE, 8'h25);
    @(negedge i_ref_clk);
    `CHK("timer", 5'h05, o_move_timer)
    i_wheel_awake = 1'b0;
    pulse(i_tick);
    `CHK("timer", 5'h04, o_move_timer)
    pulse(i_move);
    `CHK("wake", 1'b1, o_wheel_wake)
    $display("test wheel done");
  endtask
  // counts, verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence after a four cycle reset
  initial begin
    {i_rst_n, i_angle_vld, i_ratio_neg, i_den_neg, i_num_neg} = 5'h00;
    {i_wheel_awake, i_move, i_tick, i_tune_busy, i_tune_done, i_seed_done} = 6'h00;
    i_angle = 9'd0;
    i_wheel_ofs = 16'h0000;
    bad_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    t_reset();
    t_angle();
    t_ctrl();
    t_wheel();
    give_verdict();
  end
  // watchdog well past the expected run of under a hundred cycles
  initial begin
    #40000;
    bad_count++;
    give_verdict();
  end
endmodule
